// [rfbc_cfg.svh]
`ifndef RFBC_CFG_SVH
`define RFBC_CFG_SVH

// ----------------------------------------------------------------------------
// Register location and field positions
// ----------------------------------------------------------------------------
`define RFBC_ADDR_W          6
`define RFBC_DATA_W          16
`define RFBC_CTRL_B_ADDR     6'h07
`define RFBC_EN_BIT          14
`define RFBC_INV_BIT         13
`define RFBC_SINGLE_BIT      12

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RFBC_EN_RST          1'h0
`define RFBC_INV_RST         1'h0
`define RFBC_SINGLE_RST      1'h0
`define RFBC_LEVEL_RST       1'h0
`define RFBC_OE_RST          1'h0
`define RFBC_LOWZ_RST        1'h0

`endif

// [rfbc_pkg.sv]
package rfbc_pkg;

  // Radio operating state as reported by the transceiver sequencer.
  typedef enum logic [2:0] {
    RFBC_RADIO_IDLE      = 3'h0,
    RFBC_RADIO_RX        = 3'h1,
    RFBC_RADIO_TX        = 3'h2,
    RFBC_RADIO_DOZE      = 3'h3,
    RFBC_RADIO_HIBERNATE = 3'h4
  } rfbc_radio_t;

  // Control bits held for the bias output.
  typedef struct packed {
    logic biasOutEnable;
    logic biasOutInvert;
    logic singlePortSelect;
  } rfbc_ctrl_t;

  // Pin drive: level, tristate enable and strong-low marker.
  typedef struct packed {
    logic level;
    logic oe;
    logic lowZ;
  } rfbc_pin_t;

  // Drive phase of the pin, one-hot.
  typedef enum logic [2:0] {
    RFBC_PH_FLOAT = 3'h1,
    RFBC_PH_LOW   = 3'h2,
    RFBC_PH_HIGH  = 3'h4
  } rfbc_phase_t;

endpackage

// [rfbc_level_decode.sv]
`timescale 1ns/1ps
`default_nettype none

module rfbc_level_decode
  import rfbc_pkg::*;
(
  input  wire rfbc_ctrl_t  ctrl,
  input  wire rfbc_radio_t radioState,
  output rfbc_pin_t        pinNext
);

  // --------------------------------------------------------------------------
  // Pin decode
  // --------------------------------------------------------------------------
  // Enable first, then the active operation, then port mode.
  always_comb begin
    pinNext = '{level: 1'h0, oe: 1'h0, lowZ: 1'h0};
    if (!ctrl.biasOutEnable) begin
      pinNext.oe = 1'h0;
    end else begin
      pinNext.oe = 1'h1;
      case (radioState)
        RFBC_RADIO_TX: begin
          if (ctrl.singlePortSelect) begin
            pinNext.level = 1'h1;
          end else begin
            pinNext.level = ~ctrl.biasOutInvert;
          end
        end
        RFBC_RADIO_RX: begin
          if (ctrl.singlePortSelect) begin
            pinNext.level = 1'h0;
          end else begin
            pinNext.level = ctrl.biasOutInvert;
          end
        end
        RFBC_RADIO_HIBERNATE: begin
          pinNext.level = 1'h0;
          pinNext.lowZ  = 1'h1;
        end
        // Idle, doze and any unknown code pull the pin low, the safe level.
        default: begin
          pinNext.level = 1'h0;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

// [rfbc_bias_output.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rfbc_cfg.svh"

module rfbc_bias_output
  import rfbc_pkg::*;
#(
  parameter int ADDR_W = `RFBC_ADDR_W,
  parameter int DATA_W = `RFBC_DATA_W
)
(
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  input  wire logic              regWrStrobe,
  input  wire logic [ADDR_W-1:0] regWrAddr,
  input  wire logic [DATA_W-1:0] regWrData,
  input  wire rfbc_radio_t       radioState,
  output logic                   rfBiasControlOut,
  output logic                   rfBiasControlOe,
  output logic                   rfBiasLowZ,
  output rfbc_ctrl_t             biasCtrlBits,
  output rfbc_phase_t            biasPhase
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  rfbc_ctrl_t  ctrl_q;
  rfbc_ctrl_t  ctrl_d;
  rfbc_pin_t   pin_q;
  rfbc_pin_t   pin_d;
  rfbc_pin_t   pinNext;
  rfbc_phase_t phase_q;
  rfbc_phase_t phase_d;
  logic        ctrlWrHit;

  // --------------------------------------------------------------------------
  // Control register capture
  // --------------------------------------------------------------------------
  // The serial host port decoder hands over whole words; only the word for
  // the second modem control register carries the bias bits.
  assign ctrlWrHit = regWrStrobe
                  && (regWrAddr == ADDR_W'(`RFBC_CTRL_B_ADDR));

  // Other bits of that word belong to other blocks and are ignored here.
  always_comb begin
    ctrl_d = ctrl_q;
    if (ctrlWrHit) begin
      ctrl_d.biasOutEnable    = regWrData[`RFBC_EN_BIT];
      ctrl_d.biasOutInvert    = regWrData[`RFBC_INV_BIT];
      ctrl_d.singlePortSelect = regWrData[`RFBC_SINGLE_BIT];
    end
  end

  // Reset leaves the output disabled, not inverted and in dual-port mode.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q.biasOutEnable    <= `RFBC_EN_RST;
      ctrl_q.biasOutInvert    <= `RFBC_INV_RST;
      ctrl_q.singlePortSelect <= `RFBC_SINGLE_RST;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // --------------------------------------------------------------------------
  // Level decode
  // --------------------------------------------------------------------------
  // Decode works on the held bits, so a register write reaches the pin one
  // clock after it lands; radio state changes reach it on the next edge.
  rfbc_level_decode u_decode (
    .ctrl       (ctrl_q),
    .radioState (radioState),
    .pinNext    (pinNext)
  );

  // --------------------------------------------------------------------------
  // Pin registers
  // --------------------------------------------------------------------------
  // Level and enable are both registered so the pad never sees a decode
  // glitch while the radio state bus settles.
  always_comb begin
    pin_d = pinNext;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pin_q.level <= `RFBC_LEVEL_RST;
      pin_q.oe    <= `RFBC_OE_RST;
      pin_q.lowZ  <= `RFBC_LOWZ_RST;
    end else begin
      pin_q <= pin_d;
    end
  end

  // --------------------------------------------------------------------------
  // Drive phase tracker
  // --------------------------------------------------------------------------
  // Reports how the pin is being driven, for status and debug readout.
  always_comb begin
    case (phase_q)
      RFBC_PH_FLOAT: begin
        phase_d = RFBC_PH_FLOAT;
      end
      RFBC_PH_LOW: begin
        phase_d = RFBC_PH_LOW;
      end
      RFBC_PH_HIGH: begin
        phase_d = RFBC_PH_HIGH;
      end
      default: begin
        phase_d = RFBC_PH_FLOAT;
      end
    endcase
    if (!pin_d.oe) begin
      phase_d = RFBC_PH_FLOAT;
    end else if (pin_d.level) begin
      phase_d = RFBC_PH_HIGH;
    end else begin
      phase_d = RFBC_PH_LOW;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      phase_q <= RFBC_PH_FLOAT;
    end else begin
      phase_q <= phase_d;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // All outputs come straight from flip-flops.
  assign rfBiasControlOut = pin_q.level;
  assign rfBiasControlOe  = pin_q.oe;
  assign rfBiasLowZ       = pin_q.lowZ;
  assign biasCtrlBits     = ctrl_q;
  assign biasPhase        = phase_q;

endmodule

`default_nettype wire

// [rfbc_ext_rf.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// External balun or switch seen from the pin
// ----------------------------------------------------------------------------
module rfbc_ext_rf (
  input  wire logic sys_clk,
  input  wire logic pinLevel,
  input  wire logic pinOe,
  output var  logic sensed
);
  logic floatQ;
  // A released pin has no keeper; the model then shows the inverse of the
  // last driven level, so a reader that trusts a floating pin is caught.
  always_ff @(posedge sys_clk) begin
    floatQ <= pinOe ? ~pinLevel : floatQ;
  end
  assign sensed = pinOe ? pinLevel : floatQ;
endmodule
`default_nettype wire

// [rfbc_bias_output_sva.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// Pin and control write checks, one edge after the bits, the radio state or the write
// ----------------------------------------------------------------------------
module rfbc_bias_output_chk
  import rfbc_pkg::*;
#(
  parameter int ADDR_W = 6,
  parameter int DATA_W = 16
)
(
  input wire logic              sys_clk,
  input wire logic              rstn,
  input wire logic              regWrStrobe,
  input wire logic [ADDR_W-1:0] regWrAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire rfbc_radio_t       radioState,
  input wire logic              rfBiasControlOut,
  input wire logic              rfBiasControlOe,
  input wire logic              rfBiasLowZ,
  input wire rfbc_ctrl_t        biasCtrlBits,
  input wire rfbc_phase_t       biasPhase
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic en;
  logic sp;
  logic tx;
  logic rx;
  // Plain decodes; the history is taken inside the properties.
  assign en = biasCtrlBits.biasOutEnable;
  assign sp = biasCtrlBits.singlePortSelect;
  assign tx = radioState == RFBC_RADIO_TX;
  assign rx = radioState == RFBC_RADIO_RX;
  AST_OFF_FLOAT: assert property (!$past(en) |-> !rfBiasControlOe)
    else $error("pin driven while disabled");
  AST_ON_DRIVE: assert property ($past(en) |-> rfBiasControlOe)
    else $error("pin not driven while enabled");
  AST_SP_TX: assert property ($past(en && sp && tx)
    |-> rfBiasControlOut)
    else $error("single port transmit not high");
  AST_SP_RX: assert property ($past(en && sp && rx)
    |-> !rfBiasControlOut)
    else $error("single port receive not low");
  AST_DP_TX: assert property ($past(en && !sp && tx)
    |-> rfBiasControlOut != $past(biasCtrlBits.biasOutInvert))
    else $error("dual port transmit level wrong");
  AST_DP_RX: assert property ($past(en && !sp && rx)
    |-> rfBiasControlOut == $past(biasCtrlBits.biasOutInvert))
    else $error("dual port receive level wrong");
  AST_QUIET_LOW: assert property ($past(en && !tx && !rx)
    |-> !rfBiasControlOut)
    else $error("quiet state not low");
  AST_LOWZ: assert property (rfBiasLowZ
    == $past(en && radioState == RFBC_RADIO_HIBERNATE))
    else $error("strong low marker wrong");
  AST_WRITE: assert property (regWrStrobe && regWrAddr == 6'h07
    |=> biasCtrlBits == $past(regWrData[14:12]))
    else $error("control write not stored");
  CV_SP: cover property (rfBiasControlOe && $past(sp && tx));
  CV_DP: cover property (rfBiasControlOe && $past(!sp && rx));
  CV_HIB: cover property (rfBiasLowZ);
endmodule
bind rfbc_bias_output rfbc_bias_output_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
  chk_i (.sys_clk(sys_clk), .rstn(rstn), .regWrStrobe(regWrStrobe),
  .regWrAddr(regWrAddr), .regWrData(regWrData), .radioState(radioState),
  .rfBiasControlOut(rfBiasControlOut), .rfBiasControlOe(rfBiasControlOe),
  .rfBiasLowZ(rfBiasLowZ), .biasCtrlBits(biasCtrlBits),
  .biasPhase(biasPhase));
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rfbc_pkg::*;
  logic sys_clk, rstn, str, sensed, pOut, pOe, pLz, rstnNext;
  logic [5:0]  addr;
  logic [15:0] data;
  logic [31:0] r;
  rfbc_radio_t st;
  rfbc_ctrl_t  bits, pb, nb;
  rfbc_phase_t ph;
  rfbc_pin_t   ep;
  int          failures, checked;
  rfbc_bias_output rfbc_bias_output_i (.sys_clk(sys_clk), .rstn(rstn),
    .regWrStrobe(str), .regWrAddr(addr), .regWrData(data), .radioState(st),
    .rfBiasControlOut(pOut), .rfBiasControlOe(pOe), .rfBiasLowZ(pLz),
    .biasCtrlBits(bits), .biasPhase(ph));
  rfbc_ext_rf rfbc_ext_rf_i (.sys_clk(sys_clk), .pinLevel(pOut),
    .pinOe(pOe), .sensed(sensed));
  // --------------------------------------------------------------------------
  // Reference functions
  // --------------------------------------------------------------------------
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Codes 5 to 7 fall through to the quiet low, like idle.
  function automatic rfbc_pin_t expPin(rfbc_ctrl_t c, logic [2:0] s);
    if (!c.biasOutEnable) return 3'h0;
    if (s == 3'h1 || s == 3'h2)
      return {c.singlePortSelect ? s == 3'h2 : (s == 3'h2) ^ c.biasOutInvert,
              2'h2};
    return {2'h1, s == 3'h4};
  endfunction
  task automatic chk(logic [2:0] got, logic [2:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %0t output mismatch", $time);
    end
  endtask
  task automatic end_sim();
    if (failures == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // --------------------------------------------------------------------------
  // Random traffic with a mid-run reset
  // --------------------------------------------------------------------------
  initial begin
    {rstn, str, addr, data} = '0;
    st = RFBC_RADIO_IDLE;
    r = 32'h34E7;
    pb = '0;
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 3000; i++) begin
      @(posedge sys_clk);
      ep = expPin(pb, st);
      nb = (rstn && str && addr == 6'h07) ? rfbc_ctrl_t'(data[14:12]) : pb;
      rstnNext = !(i > 1500 && i < 1503);
      // A reset asserted on this edge clears the outputs before the check.
      if (!rstn || !rstnNext) {ep, nb} = '0;
      r = lfsr(r);
      if (i < 32) begin
        // Hand-written sweep: each mode and invert setting in state codes 1 to 7,
        // the unused codes 5 to 7 included; code 0 is decoded with the previous bits.
        str <= i[2:0] == 3'h0;
        addr <= 6'h07;
        data <= {2'h1, i[4:3], 12'h000};
        st <= rfbc_radio_t'(i[2:0]);
      end else begin
        str <= r[0];
        addr <= r[1] ? 6'h07 : r[7:2];
        data <= r[31:16];
        st <= rfbc_radio_t'(r[10:8]);
      end
      rstn <= rstnNext;
      #1;
      chk({pOut, pOe, pLz}, ep);
      chk(bits, nb);
      chk(ph, !ep.oe ? 3'h1 : ep.level ? 3'h4 : 3'h2);
      if (ep.oe) chk(sensed, ep.level);
      pb = nb;
    end
    end_sim();
  end
endmodule
`default_nettype wire
